//--- tsi2c_mst.sv
// Master end: write-data FIFO and a two-wire master that writes a register
// pointer, then writes bytes from the FIFO or reads bytes after a repeated START.
// Assumes a single master on the bus and a device that never stretches SCL.
`timescale 1ns/100ps
`default_nettype none
`include "tsi2c_cfg.svh"

module tsi2c_fifo #(
  parameter int unsigned W = `TSI2C_DATA_W,
  parameter int unsigned D = `TSI2C_FIFO_DEPTH
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          rdy_q;
  logic          vld_q;
  logic          push;
  logic          pop;

  assign push  = in_valid & rdy_q;
  assign pop   = out_ready & vld_q;
  assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
      vld_q <= 1'b0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q        <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d != (AW+1)'(D));
      vld_q <= (cnt_d != '0);
    end
  end

  assign in_ready  = rdy_q;
  assign out_valid = vld_q;
  assign out_data  = mem_q[rp_q];
endmodule : tsi2c_fifo

module tsi2c_mst
  import tsi2c_pkg::*;
#(
  parameter int unsigned HALF  = `TSI2C_SCL_HALF_CYC,
  parameter int unsigned DEPTH = `TSI2C_FIFO_DEPTH
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  tsi2c_if.mst            bus,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_read,
  input  wire logic [6:0] cmd_dev,
  input  wire logic [7:0] cmd_reg,
  input  wire logic [7:0] cmd_len,
  input  wire logic       wd_valid,
  output logic            wd_ready,
  input  wire logic [7:0] wd_data,
  output logic            rd_valid,
  output logic [7:0]      rd_data,
  output logic            done,
  output logic            nack
);
  logic [2:0]  sda_sync_q;
  logic        sda_q;
  logic        f_valid;
  logic        f_pop;
  logic [7:0]  f_data;
  tsi2c_mst_t  st_q;
  tsi2c_mst_t  st_d;
  tsi2c_seq_t  seq_q;
  tsi2c_seq_t  seq_d;
  logic [15:0] div_q;
  logic [15:0] div_d;
  logic [8:0]  sh_q;
  logic [8:0]  sh_d;
  logic [3:0]  bit_q;
  logic [3:0]  bit_d;
  logic        scl_oe_q;
  logic        scl_oe_d;
  logic        sda_oe_q;
  logic        sda_oe_d;
  logic        rd_q;
  logic        rd_d;
  logic [6:0]  dev_q;
  logic [6:0]  dev_d;
  logic [7:0]  reg_q;
  logic [7:0]  reg_d;
  logic [7:0]  len_q;
  logic [7:0]  len_d;
  logic        crdy_q;
  logic        crdy_d;
  logic        rv_q;
  logic        rv_d;
  logic [7:0]  rdat_q;
  logic [7:0]  rdat_d;
  logic        done_q;
  logic        done_d;
  logic        nack_q;
  logic        nack_d;
  logic        tick;
  logic [8:0]  cap;

  // An empty FIFO holds SCL low mid-write, which is the back-pressure path.
  tsi2c_fifo #(.W(`TSI2C_DATA_W), .D(DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (wd_valid),
    .in_ready  (wd_ready),
    .in_data   (wd_data),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sda_sync_q <= 3'h7;
      sda_q      <= 1'b1;
    end else begin
      sda_sync_q <= {sda_sync_q[1:0], bus.sda};
      sda_q      <= (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_q;
    end
  end

  assign tick  = (div_q == 16'(HALF - 1));
  assign cap   = {sh_q[7:0], sda_q};
  assign f_pop = (st_q == MS_LOAD) && (seq_q == SQ_WDATA) && f_valid;

  always_comb begin
    st_d = st_q; seq_d = seq_q; sh_d = sh_q; bit_d = bit_q;
    scl_oe_d = scl_oe_q; sda_oe_d = sda_oe_q;
    rd_d = rd_q; dev_d = dev_q; reg_d = reg_q; len_d = len_q;
    crdy_d = 1'b0; rv_d = 1'b0; rdat_d = rdat_q; done_d = 1'b0; nack_d = nack_q;
    div_d = (tick || st_q == MS_IDLE) ? 16'h0000 : div_q + 16'h0001;
    case (st_q)
      MS_IDLE: begin
        if (cmd_valid) begin
          crdy_d = 1'b1; rd_d = cmd_read; dev_d = cmd_dev; reg_d = cmd_reg;
          len_d = cmd_len; nack_d = 1'b0; seq_d = SQ_ADDRW; st_d = MS_START;
        end
      end
      MS_START: if (tick) begin sda_oe_d = 1'b1; st_d = MS_HOLD; end
      MS_HOLD: if (tick) begin scl_oe_d = 1'b1; st_d = MS_LOAD; end
      MS_LOAD: begin
        div_d = 16'h0000;
        bit_d = 4'h0;
        case (seq_q)
          SQ_ADDRW: sh_d = {dev_q, `TSI2C_RW_WRITE, 1'b1};
          SQ_REG:   sh_d = {reg_q, 1'b1};
          SQ_WDATA: sh_d = {f_data, 1'b1};
          SQ_ADDRR: sh_d = {dev_q, `TSI2C_RW_READ, 1'b1};
          // acknowledge all but the last read byte.
          default:  sh_d = {`TSI2C_RELEASED, len_q == 8'h01};
        endcase
        if (seq_q != SQ_WDATA || f_valid) st_d = MS_LO;
      end
      MS_LO: begin
        if (div_q == 16'h0000) sda_oe_d = ~sh_q[8];
        if (tick) begin scl_oe_d = 1'b0; st_d = MS_HI; end
      end
      MS_HI: if (tick) begin
        sh_d = cap; bit_d = bit_q + 4'h1; scl_oe_d = 1'b1; st_d = MS_LO;
        if (bit_q == `TSI2C_BIT_LAST) begin
          st_d = MS_LOAD;
          if (seq_q != SQ_RDATA && cap[0]) begin
            nack_d = 1'b1; st_d = MS_STOP_LO;
          end else begin
            case (seq_q)
              SQ_ADDRW: seq_d = SQ_REG;
              SQ_REG: begin
                if (len_q == 8'h00) st_d = MS_STOP_LO;
                else if (rd_q) begin seq_d = SQ_ADDRR; st_d = MS_RS_LO; end
                else seq_d = SQ_WDATA;
              end
              SQ_ADDRR: seq_d = SQ_RDATA;
              default: begin
                if (seq_q == SQ_RDATA) begin rv_d = 1'b1; rdat_d = cap[8:1]; end
                len_d = len_q - 8'h01;
                if (len_q == 8'h01) st_d = MS_STOP_LO;
              end
            endcase
          end
        end
      end
      MS_RS_LO: begin
        if (div_q == 16'h0000) sda_oe_d = 1'b0;
        if (tick) begin scl_oe_d = 1'b0; st_d = MS_START; end
      end
      MS_STOP_LO: begin
        if (div_q == 16'h0000) sda_oe_d = 1'b1;
        if (tick) begin scl_oe_d = 1'b0; st_d = MS_STOP_HI; end
      end
      MS_STOP_HI: if (tick) begin sda_oe_d = 1'b0; st_d = MS_STOP_END; end
      MS_STOP_END: if (tick) begin done_d = 1'b1; st_d = MS_IDLE; end
      default: st_d = MS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q <= MS_IDLE; seq_q <= SQ_ADDRW; div_q <= 16'h0000; sh_q <= 9'h1FF;
      bit_q <= 4'h0; scl_oe_q <= 1'b0; sda_oe_q <= 1'b0; rd_q <= 1'b0;
      dev_q <= 7'h00; reg_q <= 8'h00; len_q <= 8'h00; crdy_q <= 1'b0;
      rv_q <= 1'b0; rdat_q <= 8'h00; done_q <= 1'b0; nack_q <= 1'b0;
    end else begin
      st_q <= st_d; seq_q <= seq_d; div_q <= div_d; sh_q <= sh_d;
      bit_q <= bit_d; scl_oe_q <= scl_oe_d; sda_oe_q <= sda_oe_d; rd_q <= rd_d;
      dev_q <= dev_d; reg_q <= reg_d; len_q <= len_d; crdy_q <= crdy_d;
      rv_q <= rv_d; rdat_q <= rdat_d; done_q <= done_d; nack_q <= nack_d;
    end
  end

  assign bus.scl_o_m  = 1'b0;
  assign bus.scl_oe_m = scl_oe_q;
  assign bus.sda_o_m  = 1'b0;
  assign bus.sda_oe_m = sda_oe_q;
  assign cmd_ready    = crdy_q;
  assign rd_valid     = rv_q;
  assign rd_data      = rdat_q;
  assign done         = done_q;
  assign nack         = nack_q;
endmodule : tsi2c_mst
`default_nettype wire

//--- tsi2c_cfg.svh
// Constants of the two-wire register port: addresses, bit counts, timing.
// Assumes the including file uses them at the widths given here.
`ifndef TSI2C_CFG_SVH
`define TSI2C_CFG_SVH

`define TSI2C_ADDR_BASE    7'h4C
`define TSI2C_RW_READ      1'b1
`define TSI2C_RW_WRITE     1'b0
`define TSI2C_ACK_FALL     4'h8
`define TSI2C_END_FALL     4'h9
`define TSI2C_DATA_FALLS   4'h7
`define TSI2C_BIT_LAST     4'h8
`define TSI2C_REG_RESET    8'h00
`define TSI2C_RELEASED     8'hFF
`define TSI2C_REG_DEPTH    128
`define TSI2C_FIFO_DEPTH   16
`define TSI2C_DATA_W       8
`define TSI2C_CLK_MHZ      250
`define TSI2C_SCL_HALF_NS  1250
`define TSI2C_SCL_HALF_CYC ((`TSI2C_SCL_HALF_NS * `TSI2C_CLK_MHZ) / 1000)

`endif

//--- tsi2c_pkg.sv
// Types of both ends of the two-wire register port, each type used by one end.
// Assumes nothing of its surroundings.
`default_nettype none
package tsi2c_pkg;
  typedef enum logic [1:0] {ASEL_VDD, ASEL_VSS, ASEL_SDA, ASEL_SCL} tsi2c_asel_t;
  typedef enum logic [2:0] {DS_IDLE, DS_ADDR, DS_CMD, DS_WR, DS_RD, DS_SKIP} tsi2c_dst_t;
  typedef enum logic [3:0] {
    MS_IDLE, MS_START, MS_HOLD, MS_LOAD, MS_LO, MS_HI,
    MS_RS_LO, MS_STOP_LO, MS_STOP_HI, MS_STOP_END
  } tsi2c_mst_t;
  typedef enum logic [2:0] {SQ_ADDRW, SQ_REG, SQ_WDATA, SQ_ADDRR, SQ_RDATA} tsi2c_seq_t;
endpackage : tsi2c_pkg
`default_nettype wire

//--- tsi2c_if.sv
// The two open-drain wires joining master and device, with their pull-ups.
// Assumes each end drives only enables and a low output level.
`timescale 1ns/100ps
`default_nettype none
interface tsi2c_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic sda_o_d;
  logic sda_oe_d;
  logic scl;
  logic sda;
  // Pull-ups: a wire is high unless some enabled driver pulls it low.
  assign scl = scl_oe_m ? scl_o_m : 1'b1;
  assign sda = (sda_oe_m ? sda_o_m : 1'b1) & (sda_oe_d ? sda_o_d : 1'b1);
  modport dev (input scl, input sda, output sda_o_d, output sda_oe_d);
  modport mst (input sda, output scl_o_m, output scl_oe_m, output sda_o_m, output sda_oe_m);
endinterface : tsi2c_if
`default_nettype wire

//--- tsi2c_dev.sv
// Device end: two-wire slave giving an external master access to a register file.
// Assumes the master makes every clock pulse; SCL and SDA arrive asynchronously.
`timescale 1ns/100ps
`default_nettype none
`include "tsi2c_cfg.svh"

module tsi2c_dev
  import tsi2c_pkg::*;
#(
  parameter int unsigned DEPTH = `TSI2C_REG_DEPTH
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  tsi2c_if.dev             bus,
  input  wire tsi2c_asel_t addr_sel,
  input  wire logic [7:0]  usr_addr,
  output logic [7:0]       usr_rdata,
  output logic             wr_stb,
  output logic [7:0]       wr_addr,
  output logic [7:0]       wr_data,
  output logic             busy
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [2:0]  scl_sync_q;
  logic [2:0]  sda_sync_q;
  logic        scl_q;
  logic        scl_d;
  logic        sda_q;
  logic        sda_d;
  tsi2c_asel_t asel_q;
  logic        strap_done_q;
  logic [6:0]  own_addr;
  tsi2c_dst_t  st_q;
  tsi2c_dst_t  st_d;
  logic [3:0]  cnt_q;
  logic [3:0]  cnt_d;
  logic [7:0]  sh_q;
  logic [7:0]  sh_d;
  logic        oe_q;
  logic        oe_d;
  logic [7:0]  ptr_q;
  logic [7:0]  ptr_d;
  logic        rw_q;
  logic        rw_d;
  logic        mack_q;
  logic        mack_d;
  logic [7:0]  mem_q [DEPTH];
  logic [7:0]  mem_d [DEPTH];
  logic        stb_q;
  logic        stb_d;
  logic [7:0]  waddr_q;
  logic [7:0]  waddr_d;
  logic [7:0]  wdat_q;
  logic [7:0]  wdat_d;
  logic [7:0]  urd_q;
  logic [7:0]  urd_d;
  logic [7:0]  rd_byte;
  logic        ptr_in;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        busy_q;
  logic        busy_d;

  // A level counts once the second and third stages agree; the first stage
  // feeds only the second, so no logic ever sees a metastable value.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], bus.scl};
      sda_sync_q <= {sda_sync_q[1:0], bus.sda};
      scl_q      <= scl_d;
      sda_q      <= sda_d;
    end
  end

  assign scl_d    = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_q;
  assign sda_d    = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_q;
  assign scl_rise = scl_d & ~scl_q;
  assign scl_fall = ~scl_d & scl_q;
  assign start_c  = scl_q & scl_d & sda_q & ~sda_d;
  assign stop_c   = scl_q & scl_d & ~sda_q & sda_d;

  // The strap is caught after reset release, never inside the reset branch.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      asel_q       <= ASEL_VDD;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      asel_q       <= addr_sel;
      strap_done_q <= 1'b1;
    end
  end

  assign own_addr = `TSI2C_ADDR_BASE + {5'h00, asel_q};

  // Pointers past the register file read as zero and swallow writes.
  assign ptr_in  = {1'b0, ptr_q} < 9'(DEPTH);
  assign rd_byte = ptr_in ? mem_q[ptr_q[PW-1:0]] : `TSI2C_REG_RESET;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    oe_d    = oe_q;
    ptr_d   = ptr_q;
    rw_d    = rw_q;
    mack_d  = mack_q;
    mem_d   = mem_q;
    stb_d   = 1'b0;
    waddr_d = waddr_q;
    wdat_d  = wdat_q;
    urd_d   = ({1'b0, usr_addr} < 9'(DEPTH)) ? mem_q[usr_addr[PW-1:0]] : `TSI2C_REG_RESET;
    if (start_c) begin
      st_d  = DS_ADDR;
      cnt_d = 4'h0;
      oe_d  = 1'b0;
    end else if (stop_c) begin
      st_d = DS_IDLE;
      oe_d = 1'b0;
    end else if (st_q != DS_IDLE && st_q != DS_SKIP) begin
      if (scl_rise) begin
        if (cnt_q < `TSI2C_ACK_FALL && st_q != DS_RD) begin
          sh_d = {sh_q[6:0], sda_q};
        end
        if (cnt_q == `TSI2C_ACK_FALL && st_q == DS_RD) begin
          mack_d = ~sda_q;
        end
        cnt_d = cnt_q + 4'h1;
      end else if (scl_fall && cnt_q == `TSI2C_ACK_FALL) begin
        case (st_q)
          DS_ADDR: begin
            if (sh_q[7:1] == own_addr) begin
              oe_d = 1'b1;
              rw_d = sh_q[0];
            end else begin
              st_d = DS_SKIP;
            end
          end
          DS_CMD: begin
            ptr_d = sh_q;
            oe_d  = 1'b1;
          end
          DS_WR: begin
            if (ptr_in) begin
              mem_d[ptr_q[PW-1:0]] = sh_q;
            end
            ptr_d   = ptr_q + 8'h01;
            stb_d   = 1'b1;
            waddr_d = ptr_q;
            wdat_d  = sh_q;
            oe_d    = 1'b1;
          end
          DS_RD: begin
            oe_d = 1'b0;
          end
          default: begin
            oe_d = 1'b0;
          end
        endcase
      end else if (scl_fall && cnt_q == `TSI2C_END_FALL) begin
        cnt_d = 4'h0;
        oe_d  = 1'b0;
        case (st_q)
          DS_ADDR: begin
            if (rw_q == `TSI2C_RW_READ) begin
              st_d  = DS_RD;
              sh_d  = rd_byte;
              oe_d  = ~rd_byte[7];
              ptr_d = ptr_q + 8'h01;
            end else begin
              st_d = DS_CMD;
            end
          end
          DS_CMD: st_d = DS_WR;
          DS_WR: st_d = DS_WR;
          DS_RD: begin
            if (mack_q) begin
              sh_d  = rd_byte;
              oe_d  = ~rd_byte[7];
              ptr_d = ptr_q + 8'h01;
            end else begin
              st_d = DS_SKIP;
            end
          end
          default: st_d = DS_SKIP;
        endcase
      end else if (scl_fall && st_q == DS_RD && cnt_q != 4'h0 && cnt_q <= `TSI2C_DATA_FALLS) begin
        sh_d = {sh_q[6:0], 1'b1};
        oe_d = ~sh_q[6];
      end
    end
    busy_d = (st_d != DS_IDLE);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q    <= DS_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= `TSI2C_RELEASED;
      oe_q    <= 1'b0;
      ptr_q   <= `TSI2C_REG_RESET;
      rw_q    <= `TSI2C_RW_WRITE;
      mack_q  <= 1'b0;
      stb_q   <= 1'b0;
      waddr_q <= `TSI2C_REG_RESET;
      wdat_q  <= `TSI2C_REG_RESET;
      urd_q   <= `TSI2C_REG_RESET;
      busy_q  <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= `TSI2C_REG_RESET;
      end
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      oe_q    <= oe_d;
      ptr_q   <= ptr_d;
      rw_q    <= rw_d;
      mack_q  <= mack_d;
      stb_q   <= stb_d;
      waddr_q <= waddr_d;
      wdat_q  <= wdat_d;
      urd_q   <= urd_d;
      busy_q  <= busy_d;
      mem_q   <= mem_d;
    end
  end

  assign bus.sda_o_d  = 1'b0;
  assign bus.sda_oe_d = oe_q;
  assign usr_rdata    = urd_q;
  assign wr_stb       = stb_q;
  assign wr_addr      = waddr_q;
  assign wr_data      = wdat_q;
  assign busy         = busy_q;
endmodule : tsi2c_dev
`default_nettype wire

//--- tsi2c_properties.sv
// Checker for the two-wire link joining the master and device ends.
// Assumes raw wire levels, one clock domain and a device that only pulls SDA.
`timescale 1ns/100ps
`default_nettype none
`include "tsi2c_cfg.svh"
module tsi2c_properties
  import tsi2c_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        scl,
  input wire logic        sda,
  input wire logic        sda_o_d,
  input wire logic        sda_oe_d,
  input wire tsi2c_asel_t addr_sel
);
  logic       scl_q, sda_q, busy_q, rw_q, match_q, nack_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [1:0] byte_q;
  logic       start_c, stop_c;
  logic [6:0] own;
  assign start_c = scl && scl_q && sda_q && !sda;
  assign stop_c  = scl && scl_q && !sda_q && sda;
  assign own     = `TSI2C_ADDR_BASE + {5'h00, addr_sel};
  // The count restarts at START and STOP, so the rise that sets up either shows as one.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {scl_q, sda_q, busy_q, rw_q, match_q, nack_q} <= 6'h30;
      {cnt_q, sh_q, byte_q} <= 14'h0000;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_c || stop_c) begin
        {busy_q, match_q, nack_q} <= {start_c, 2'b00};
        {cnt_q, byte_q} <= 6'h00;
      end else if (scl && !scl_q) begin
        cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
        if (cnt_q != 4'h8) begin
          sh_q <= {sh_q[6:0], sda};
        end else begin
          if (byte_q == 2'h0) begin
            {rw_q, match_q} <= {sh_q[0], sh_q[7:1] == own};
          end
          if (byte_q != 2'h0 && rw_q && sda) begin
            nack_q <= 1'b1;
          end
          byte_q <= (byte_q == 2'h3) ? byte_q : byte_q + 2'h1;
        end
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence ack_rise;
    $rose(scl) && cnt_q == 4'h8;
  endsequence
  idle_release_a: assert property (!busy_q |-> scl && !sda_oe_d)
    else $error("link not released while idle");
  dev_stable_a: assert property (scl && $past(scl) |-> $stable(sda_oe_d))
    else $error("device moved SDA while SCL high");
  nine_pulse_a: assert property ((start_c || stop_c) && busy_q |-> cnt_q == 4'h1)
    else $error("byte framing not nine pulses");
  ack_stable_a: assert property (ack_rise ##0 sda_oe_d |-> sda_oe_d [*6])
    else $error("acknowledge not held through pulse");
  ack_write_a: assert property (ack_rise ##0 (byte_q != 2'h0 && match_q && !rw_q) |-> !sda)
    else $error("written byte not acknowledged");
  master_ack_a: assert property (ack_rise ##0 (byte_q != 2'h0 && rw_q) |-> !sda_oe_d)
    else $error("device drove master acknowledge");
  addr_match_a: assert property (ack_rise ##0 (byte_q == 2'h0) |-> sda == (sh_q[7:1] != own))
    else $error("address acknowledge wrong");
  drive_low_a: assert property (sda_oe_d |-> sda_o_d == 1'b0 && !sda)
    else $error("device drove SDA high");
  nack_release_a: assert property (nack_q |-> !sda_oe_d)
    else $error("SDA held after master refusal");
  foreign_quiet_a: assert property (busy_q && byte_q != 2'h0 && !match_q |-> !sda_oe_d)
    else $error("SDA driven for foreign address");
endmodule : tsi2c_properties
`default_nettype wire

//--- tb.sv
// Self-checking bench: master end drives the device end across the link.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "tsi2c_cfg.svh"
module tb;
  import tsi2c_pkg::*;
  localparam int LIMIT = 60000;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  tsi2c_asel_t addr_sel = ASEL_VDD;
  logic        cmd_valid = 1'b0, cmd_read = 1'b0, wd_valid = 1'b0;
  logic [6:0]  cmd_dev = 7'h4C;
  logic [7:0]  cmd_reg = 8'h00, cmd_len = 8'h00, wd_data = 8'h00, usr_addr = 8'h00;
  logic        cmd_ready, wd_ready, rd_valid, done, nack, wr_stb, busy;
  logic [7:0]  rd_data, wr_addr, wr_data, usr_rdata, base;
  logic [7:0]  mem [0:255];
  logic [7:0]  src[$], pend[$], rd_q[$];
  logic [15:0] wr_q[$];
  int          n_fail = 0, cmp_count = 0, cyc = 0;
  tsi2c_if bus_if();
  tsi2c_dev i_tsi2c_dev (.clk_sys(clk_sys), .reset(reset), .bus(bus_if),
    .addr_sel(addr_sel), .usr_addr(usr_addr), .usr_rdata(usr_rdata),
    .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy));
  tsi2c_mst #(.HALF(8)) i_tsi2c_mst (.clk_sys(clk_sys), .reset(reset), .bus(bus_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_dev(cmd_dev),
    .cmd_reg(cmd_reg), .cmd_len(cmd_len), .wd_valid(wd_valid), .wd_ready(wd_ready),
    .wd_data(wd_data), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack(nack));
  tsi2c_properties i_tsi2c_properties (.clk_sys(clk_sys), .reset(reset), .scl(bus_if.scl),
    .sda(bus_if.sda), .sda_o_d(bus_if.sda_o_d), .sda_oe_d(bus_if.sda_oe_d),
    .addr_sel(addr_sel));
  always #2 clk_sys = ~clk_sys;
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic do_reset();
    reset = 1'b1;
    repeat (12) @(negedge clk_sys);
    reset = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
  endtask : do_reset
  task automatic gen(input int n);
    logic [7:0] b;
    repeat (n) begin
      b = 8'($urandom);
      src.push_back(b);
      pend.push_back(b);
    end
  endtask : gen
  // Valid drops while the buffer is full so that no byte is offered twice.
  task automatic fill(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      if (wd_ready !== 1'b1) begin
        wd_valid = 1'b0;
        while (wd_ready !== 1'b1) @(negedge clk_sys);
      end
      wd_valid = 1'b1;
      wd_data = src.pop_front();
    end
    @(negedge clk_sys);
    wd_valid = 1'b0;
  endtask : fill
  task automatic xfer(input logic rd, input logic [6:0] dev, input logic [7:0] rg,
                      input logic [7:0] len, input logic ack);
    for (int i = 0; i < len; i++) begin
      if (rd) begin
        rd_q.push_back(mem[8'(rg + i)]);
      end else begin
        mem[8'(rg + i)] = pend[0];
        wr_q.push_back({8'(rg + i), pend.pop_front()});
      end
    end
    @(negedge clk_sys);
    {cmd_valid, cmd_read, cmd_dev, cmd_reg, cmd_len} = {1'b1, rd, dev, rg, len};
    do @(negedge clk_sys); while (cmd_ready !== 1'b1);
    cmd_valid = 1'b0;
    do @(negedge clk_sys); while (done !== 1'b1);
    check({15'h0000, nack}, {15'h0000, !ack});
    check({15'h0000, busy}, 16'h0000);
  endtask : xfer
  always @(negedge clk_sys) begin
    if (wr_stb === 1'b1) check({wr_addr, wr_data}, wr_q.size() ? wr_q.pop_front() : 16'hxxxx);
    if (rd_valid === 1'b1) check({8'h00, rd_data}, rd_q.size() ? {8'h00, rd_q.pop_front()} : 16'hxxxx);
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'h4D498D69));
    for (int k = 0; k < 4; k++) begin
      addr_sel = tsi2c_asel_t'(k);
      do_reset();
      gen(1);
      fill(1);
      xfer(1'b0, 7'h4C + 7'(k), 8'h20, 8'h01, 1'b1);
      xfer(1'b0, 7'h4C + 7'((k + 1) % 4), 8'h20, 8'h00, 1'b0);
    end
    base = 8'($urandom_range(95));
    gen(16);
    fill(16);
    check({15'h0000, wd_ready}, 16'h0000);
    xfer(1'b0, 7'h4F, base, 8'h10, 1'b1);
    xfer(1'b0, 7'h4F, 8'h70, 8'h00, 1'b1);
    xfer(1'b1, 7'h4F, base, 8'h10, 1'b1);
    gen(4);
    fill(2);
    // The empty buffer stalls the link with SCL low until data comes.
    fork
      xfer(1'b0, 7'h4F, 8'h7C, 8'h04, 1'b1);
      begin
        repeat (600) @(negedge clk_sys);
        fill(2);
      end
    join
    xfer(1'b1, 7'h4F, 8'h7C, 8'h04, 1'b1);
    gen(1);
    fill(1);
    xfer(1'b0, 7'h4F, 8'h5E, 8'h01, 1'b1);
    usr_addr = 8'h7D;
    repeat (2) @(negedge clk_sys);
    check({8'h00, usr_rdata}, {8'h00, mem[8'h7D]});
    usr_addr = 8'h90;
    repeat (2) @(negedge clk_sys);
    check({8'h00, usr_rdata}, 16'h0000);
    check(16'(wr_q.size() + rd_q.size()), 16'h0000);
    complete_run();
  end
endmodule : tb
`default_nettype wire
